// file: core/fbp_ctrl.sv
// Flash controller: single-cycle reads, word program, block erase, region protection.
// Assumes requests are synchronous to ref_clk and a protection table from system setup.
// How it works
// - Array holds CAP_BYTES, 256 KB by default; addresses outside that capacity are flagged as errors.
// - Reads answer on the next clock edge, with no wait states.
// - Erase clears one 1-KB block only, leaving every other block intact.
// - After erase every bit of the block reads back as one.
// - Protection is set per aligned 2-KB pair: open, read-only or execute-only.
// - Read-only regions refuse erase and program but allow all reads.
// - Execute-only regions refuse modify; only instruction fetches get contents.
`timescale 1ns/1ps
module fbp_ctrl
   import fbp_pkg::*;
#(
   parameter int unsigned CAP_BYTES = FBP_CAPACITY_BYTES,
   parameter int unsigned BLK_BYTES = FBP_BLOCK_BYTES
)
(
   // Clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   // Protection table, two bits per region
   input  wire logic [2*(CAP_BYTES/(BLK_BYTES*FBP_REGION_BLOCKS))-1:0] prot_map,
   // Requests
   input  wire fbp_rd_req_t                  rd_req,
   input  wire fbp_mod_req_t                 mod_req,
   // Answers
   output fbp_rd_rsp_t                       rd_rsp,
   output logic                              mod_done,
   output logic                              mod_err
);
   localparam int unsigned WORDS     = CAP_BYTES / FBP_WORD_BYTES;
   localparam int unsigned BLK_WORDS = BLK_BYTES / FBP_WORD_BYTES;
   localparam int unsigned REGIONS   = CAP_BYTES / (BLK_BYTES * FBP_REGION_BLOCKS);
   localparam int unsigned WA_W      = $clog2(WORDS);
   localparam int unsigned BW_W      = $clog2(BLK_WORDS);
   localparam int unsigned RG_W      = (REGIONS > 1) ? $clog2(REGIONS) : 1;
   localparam logic [WA_W-1:0] BLK_MASK = WA_W'(BLK_WORDS - 1);
   localparam logic [BW_W-1:0] LAST_IDX = BW_W'(BLK_WORDS - 1);

   // Geometry the logic can serve
   if (CAP_BYTES == 0 || CAP_BYTES > FBP_CAPACITY_BYTES
       || CAP_BYTES % (BLK_BYTES * FBP_REGION_BLOCKS) != 0)
   begin : g_bad_capacity
      $error("fbp_ctrl: capacity must be whole regions within the array");
   end
   if (BLK_BYTES < 2 * FBP_WORD_BYTES || (BLK_BYTES & (BLK_BYTES - 1)) != 0)
   begin : g_bad_block
      $error("fbp_ctrl: block size must be a power of two of at least two words");
   end

   // Region index of a byte address
   function automatic logic [RG_W-1:0] region_of(input logic [FBP_ADDR_W-1:0] a);
      region_of = RG_W'(a / (BLK_BYTES * FBP_REGION_BLOCKS));
   endfunction : region_of

   // Mode of a region
   function automatic fbp_prot_t mode_of(input logic [RG_W-1:0] r);
      mode_of = fbp_prot_t'(prot_map[2*r +: 2]);
   endfunction : mode_of

   // Address lies inside the array
   function automatic logic in_range_of(input logic [FBP_ADDR_W-1:0] a);
      in_range_of = (32'(a) < CAP_BYTES);
   endfunction : in_range_of

   // Word index of a byte address, low two bits dropped
   function automatic logic [WA_W-1:0] word_of(input logic [FBP_ADDR_W-1:0] a);
      word_of = WA_W'(a / FBP_WORD_BYTES);
   endfunction : word_of

   // Erase walk states
   typedef enum logic [1:0]
   {
      FBP_ST_IDLE  = 2'b01,
      FBP_ST_ERASE = 2'b10
   } fbp_state_t;

   logic [31:0]      mem [WORDS];
   fbp_state_t       state;
   fbp_state_t       next_state;
   logic [WA_W-1:0]  ers_base;
   logic [WA_W-1:0]  next_ers_base;
   logic [BW_W-1:0]  ers_idx;
   logic [BW_W-1:0]  next_ers_idx;

   // Read decode
   wire fbp_prot_t       rd_mode;
   wire logic            rd_in_range;
   wire logic            rd_allow;
   wire logic            rd_grant;
   wire logic [WA_W-1:0] rd_word;
   wire fbp_rd_rsp_t     next_rd_rsp;

   // Modify decode
   wire fbp_prot_t       md_mode;
   wire logic            md_in_range;
   wire logic            md_allow;
   wire logic [WA_W-1:0] md_word;
   wire logic            md_take;
   wire logic            md_go;
   wire logic            md_erase_go;
   wire logic            md_prog_go;
   wire logic            next_mod_done;
   wire logic            next_mod_err;

   // Erase walk decode
   wire logic            ers_active;
   wire logic            ers_last;
   wire logic [WA_W-1:0] ers_word;

   // Read path
   assign rd_mode     = mode_of(region_of(rd_req.addr));
   assign rd_in_range = in_range_of(rd_req.addr);
   assign rd_word     = word_of(rd_req.addr);
   assign rd_grant    = rd_req.valid && rd_in_range && rd_allow;

   // Answer word for the next edge
   assign next_rd_rsp = '{valid: rd_req.valid,
                          err:   rd_req.valid && !rd_grant,
                          rdata: rd_grant ? mem[rd_word] : FBP_DENIED_WORD};

   // Modify path
   assign md_mode       = mode_of(region_of(mod_req.addr));
   assign md_in_range   = in_range_of(mod_req.addr);
   assign md_word       = word_of(mod_req.addr);
   assign md_take       = mod_req.valid && (state == FBP_ST_IDLE);
   assign md_go         = md_take && md_in_range && md_allow;
   assign md_erase_go   = md_go && mod_req.erase;
   assign md_prog_go    = md_go && !mod_req.erase;
   assign next_mod_done = (md_take && !md_erase_go) || (ers_active && ers_last);
   assign next_mod_err  = md_take && !md_go;

   // Erase walk
   assign ers_active    = (state == FBP_ST_ERASE);
   assign ers_last      = (ers_idx == LAST_IDX);
   assign ers_word      = ers_base | WA_W'(ers_idx);
   assign next_ers_base = md_erase_go ? (md_word & ~BLK_MASK) : ers_base;
   assign next_ers_idx  = md_erase_go ? '0 : (ers_active ? ers_idx + BW_W'(1) : ers_idx);

   fbp_guard u_rd_guard
   (
      .mode      (rd_mode),
      .src       (rd_req.src),
      .is_modify (1'b0),
      .allow     (rd_allow)
   );

   fbp_guard u_md_guard
   (
      .mode      (md_mode),
      .src       (FBP_SRC_DATA),
      .is_modify (1'b1),
      .allow     (md_allow)
   );

   always_comb
   begin
      next_state = state;
      unique case (state)
         FBP_ST_IDLE:
            if (md_go && mod_req.erase)
               next_state = FBP_ST_ERASE;
         FBP_ST_ERASE:
            if (ers_last)
               next_state = FBP_ST_IDLE;
         default:
            next_state = FBP_ST_IDLE;
      endcase
   end

   // Read answer, one cycle after request
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rd_rsp <= '0;
      else
         rd_rsp <= next_rd_rsp;
   end

   // Erase walk state
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         state <= FBP_ST_IDLE;
      else
         state <= next_state;
   end

   // Erase walk position
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ers_base <= '0;
         ers_idx  <= '0;
      end
      else
      begin
         ers_base <= next_ers_base;
         ers_idx  <= next_ers_idx;
      end
   end

   // Modify answer, a one-cycle pulse
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         mod_done <= 1'b0;
         mod_err  <= 1'b0;
      end
      else
      begin
         mod_done <= next_mod_done;
         mod_err  <= next_mod_err;
      end
   end

   // Array storage, erase walks one block word by word
   always_ff @(posedge ref_clk)
   begin
      if (ers_active)
         mem[ers_word] <= FBP_ERASED_WORD;
      else if (md_prog_go)
         mem[md_word] <= mem[md_word] & mod_req.wdata;
   end
endmodule : fbp_ctrl

// file: core/fbp_pkg.sv
// Package for the flash block erase and protection controller.
// Assumes a single clock domain and a word-organised array held in flip-flops.
package fbp_pkg;

   // Array geometry
   localparam int unsigned FBP_CAPACITY_BYTES = 262144;
   localparam int unsigned FBP_BLOCK_BYTES    = 1024;
   localparam int unsigned FBP_REGION_BLOCKS  = 2;
   localparam int unsigned FBP_WORD_BYTES     = 4;
   localparam int unsigned FBP_ADDR_W         = 18;

   // Values
   localparam logic [31:0] FBP_ERASED_WORD = 32'hffff_ffff;
   localparam logic [31:0] FBP_DENIED_WORD = 32'h0000_0000;

   // Protection modes
   typedef enum logic [1:0]
   {
      FBP_PROT_OPEN  = 2'h0,
      FBP_PROT_RDONLY = 2'h1,
      FBP_PROT_XONLY = 2'h2
   } fbp_prot_t;

   // Requester of a read
   typedef enum logic [1:0]
   {
      FBP_SRC_FETCH = 2'h0,
      FBP_SRC_DATA  = 2'h1,
      FBP_SRC_DEBUG = 2'h2
   } fbp_src_t;

   // Read request
   typedef struct packed
   {
      logic                  valid;
      fbp_src_t              src;
      logic [FBP_ADDR_W-1:0] addr;
   } fbp_rd_req_t;

   // Modify request: program a word or erase a block
   typedef struct packed
   {
      logic                  valid;
      logic                  erase;
      logic [FBP_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
   } fbp_mod_req_t;

   // Read answer
   typedef struct packed
   {
      logic        valid;
      logic        err;
      logic [31:0] rdata;
   } fbp_rd_rsp_t;

endpackage : fbp_pkg

// file: core/fbp_guard.sv
// Protection check for one access against the region protection table.
// Assumes the caller supplies the region mode already selected.
`timescale 1ns/1ps
module fbp_guard
   import fbp_pkg::*;
(
   // Access
   input  wire fbp_prot_t mode,
   input  wire fbp_src_t  src,
   input  wire logic      is_modify,
   // Verdict
   output logic           allow
);
   wire logic read_ok;
   wire logic mod_ok;

   assign read_ok = (mode != FBP_PROT_XONLY) || (src == FBP_SRC_FETCH);
   assign mod_ok  = (mode == FBP_PROT_OPEN);
   assign allow   = is_modify ? mod_ok : read_ok;
endmodule : fbp_guard

// file: tb/fbp_ctrl_assertions.sv
// Port checker for the flash controller.
// Assumes binding onto fbp_ctrl with its parameters handed on.
`timescale 1ns/1ps
module fbp_ctrl_chk
   import fbp_pkg::*;
#(
   parameter int unsigned CAP_BYTES = FBP_CAPACITY_BYTES,
   parameter int unsigned BLK_BYTES = FBP_BLOCK_BYTES
)
(
   // Clock, reset, table
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [2*(CAP_BYTES/(BLK_BYTES*FBP_REGION_BLOCKS))-1:0] prot_map,
   // Requests and answers
   input wire fbp_rd_req_t  rd_req,
   input wire fbp_mod_req_t mod_req,
   input wire fbp_rd_rsp_t  rd_rsp,
   input wire logic         mod_done,
   input wire logic         mod_err
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic       rin = rd_req.addr < CAP_BYTES;
   wire logic       min = mod_req.addr < CAP_BYTES;
   wire logic [1:0] rm  = prot_map[2*(rd_req.addr/(2*BLK_BYTES))+:2];
   wire logic [1:0] mm  = prot_map[2*(mod_req.addr/(2*BLK_BYTES))+:2];
   wire logic       mpr = min && (mm != FBP_PROT_OPEN);
   wire logic       mop = min && (mm == FBP_PROT_OPEN);
   sequence s_clear;
      !mod_done [*8];
   endsequence
   sequence s_done_ok;
      mod_done && !mod_err;
   endsequence
   a_rd_answer: assert property (rd_req.valid |=> rd_rsp.valid) else $error("read late");
   a_rd_idle: assert property (!rd_req.valid |=> !rd_rsp.valid && !rd_rsp.err) else $error("stray answer");
   a_rd_range: assert property (rd_req.valid && !rin |=> rd_rsp.err && rd_rsp.rdata == FBP_DENIED_WORD)
      else $error("range read");
   a_rd_xonly: assert property (rd_req.valid && rin && rm == FBP_PROT_XONLY && rd_req.src != FBP_SRC_FETCH
      |=> rd_rsp.err && rd_rsp.rdata == FBP_DENIED_WORD) else $error("xonly read");
   a_rd_allow: assert property (rd_req.valid && rin && (rm != FBP_PROT_XONLY || rd_req.src == FBP_SRC_FETCH)
      |=> !rd_rsp.err) else $error("read refused");
   a_mod_refuse: assert property ($rose(mod_req.valid) && mpr |=> mod_done && mod_err)
      else $error("modify allowed");
   a_prog_ok: assert property ($rose(mod_req.valid) && !mod_req.erase && mop |=> s_done_ok)
      else $error("program");
   a_erase_len: assert property ($rose(mod_req.valid) && mod_req.erase && mop |=> s_clear ##249 s_done_ok)
      else $error("erase time");
   a_err_done: assert property (mod_err |-> mod_done) else $error("lone error");
endmodule : fbp_ctrl_chk
bind fbp_ctrl fbp_ctrl_chk #(.CAP_BYTES(CAP_BYTES), .BLK_BYTES(BLK_BYTES)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .prot_map(prot_map), .rd_req(rd_req), .mod_req(mod_req), .rd_rsp(rd_rsp), .mod_done(mod_done), .mod_err(mod_err));

// file: tb/fbp_cpu.sv
// Processor-side requester: fetch, data and debug reads, program, erase.
// Assumes requests launch 1 ns after a rising edge of ref_clk.
`timescale 1ns/1ps
module fbp_cpu
   import fbp_pkg::*;
(
   // Clock and answers
   input wire logic        ref_clk,
   input wire fbp_rd_rsp_t rd_rsp,
   input wire logic        mod_done,
   input wire logic        mod_err,
   // Requests
   output fbp_rd_req_t     rd_req,
   output fbp_mod_req_t    mod_req
);
   initial
   begin
      rd_req = '0;
      mod_req = '0;
   end
   task automatic rd(input fbp_src_t s, input logic [17:0] a, output fbp_rd_rsp_t r);
      @(posedge ref_clk) #1;
      rd_req = {1'b1, s, a};
      @(posedge ref_clk) #1;
      r = rd_rsp;
      rd_req = {1'b0, s, ~a};
   endtask : rd
   task automatic wr(input logic e, input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk) #1;
      mod_req = {1'b1, e, a, d};
      for (int k = 0; k < 300 && !mod_done; k++) @(posedge ref_clk) #1;
      r = {mod_done, mod_err};
      mod_req = {1'b0, e, ~a, ~d};
   endtask : wr
endmodule : fbp_cpu

// file: tb/testbench.sv
// Self-checking bench for the flash controller with an 8 KB array.
// Assumes the processor model drives all requests.
`timescale 1ns/1ps
module testbench
   import fbp_pkg::*;
;
   logic         ref_clk = 0;
   logic         rst_n = 0;
   logic [7:0]   prot_map = '0;
   fbp_rd_req_t  rd_req;
   fbp_mod_req_t mod_req;
   fbp_rd_rsp_t  rd_rsp, r;
   logic         mod_done, mod_err;
   logic [1:0]   m;
   int           errors = 0;
   int           checks = 0;
   always #25 ref_clk = ~ref_clk;
   fbp_ctrl #(.CAP_BYTES(8192), .BLK_BYTES(1024)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .prot_map(prot_map),
      .rd_req(rd_req), .mod_req(mod_req), .rd_rsp(rd_rsp), .mod_done(mod_done), .mod_err(mod_err));
   fbp_cpu cpu (.ref_clk(ref_clk), .rd_rsp(rd_rsp), .mod_done(mod_done), .mod_err(mod_err),
      .rd_req(rd_req), .mod_req(mod_req));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task summarize;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task t_erase;
      cpu.wr(1, 18'h0, 0, m);
      chk(m, 2'b10);
      cpu.rd(FBP_SRC_DATA, 18'h3fc, r);
      chk(r, {2'b10, FBP_ERASED_WORD});
      cpu.wr(0, 18'h3fc, 32'h1234_5678, m);
      chk(m, 2'b10);
      cpu.wr(0, 18'h3fc, 32'hff00_ffff, m);
      chk(m, 2'b10);
      cpu.wr(1, 18'h400, 0, m);
      chk(m, 2'b10);
      cpu.rd(FBP_SRC_FETCH, 18'h7fc, r);
      chk(r, {2'b10, FBP_ERASED_WORD});
      cpu.rd(FBP_SRC_DEBUG, 18'h3fc, r);
      chk(r, {2'b10, 32'h1200_5678});
   endtask : t_erase
   task t_protect;
      cpu.wr(1, 18'h800, 0, m);
      chk(m, 2'b10);
      cpu.wr(1, 18'h1000, 0, m);
      chk(m, 2'b10);
      prot_map = 8'h24;
      cpu.wr(0, 18'h800, 0, m);
      chk(m, 2'b11);
      cpu.wr(1, 18'h800, 0, m);
      chk(m, 2'b11);
      cpu.rd(FBP_SRC_DATA, 18'h800, r);
      chk(r, {2'b10, FBP_ERASED_WORD});
      cpu.wr(1, 18'h1000, 0, m);
      chk(m, 2'b11);
      cpu.rd(FBP_SRC_FETCH, 18'h1004, r);
      chk(r, {2'b10, FBP_ERASED_WORD});
      cpu.rd(FBP_SRC_DATA, 18'h1004, r);
      chk(r, {2'b11, FBP_DENIED_WORD});
      cpu.rd(FBP_SRC_DEBUG, 18'h1004, r);
      chk(r, {2'b11, FBP_DENIED_WORD});
   endtask : t_protect
   task t_range;
      cpu.rd(FBP_SRC_FETCH, 18'h2000, r);
      chk(r, {2'b11, FBP_DENIED_WORD});
      cpu.wr(0, 18'h2000, 0, m);
      chk(m, 2'b11);
   endtask : t_range
   initial
   begin
      repeat (3) @(posedge ref_clk);
      #1 rst_n = 1;
      t_erase;
      t_protect;
      t_range;
      summarize;
   end
   initial
   begin
      #500000;
      errors++;
      summarize;
   end
endmodule : testbench
